// file: src/psh_defines.vh
// Constants for the packed single to half converter
`ifndef PSH_DEFINES_VH
`define PSH_DEFINES_VH

`define PSH_AW            7
`define PSH_OFF_CTRL      7'h00
`define PSH_OFF_INSN      7'h04
`define PSH_OFF_CSR       7'h08
`define PSH_OFF_STAT      7'h0C
`define PSH_OFF_MASK      7'h10
`define PSH_IDX_SRC       2'h1
`define PSH_IDX_DST       2'h2
`define PSH_IDX_MEM       3'h6

`define PSH_CTRL_START    0
`define PSH_INSN_RC       1:0
`define PSH_INSN_MS       2
`define PSH_INSN_OPC      15:8
`define PSH_INSN_MAP      17:16
`define PSH_INSN_PP       19:18
`define PSH_INSN_W        20
`define PSH_INSN_VVVV     24:21
`define PSH_INSN_L        25
`define PSH_INSN_MOD      27:26
`define PSH_INSN_RST      28'h1E01D01
`define PSH_MAP_0F3A      2'h3
`define PSH_OPC_CVT       8'h1D
`define PSH_PP_66         2'h1
`define PSH_VVVV_ONES     4'hF
`define PSH_MOD_REG       2'h3

`define PSH_CSR_FLAGS     4:0
`define PSH_CSR_MASKS     12:8
`define PSH_CSR_DAZ       13
`define PSH_CSR_FTZ       14
`define PSH_CSR_RC        16:15
`define PSH_CSR_RST       17'h01F00
`define PSH_FL_IE         0
`define PSH_FL_DE         1
`define PSH_FL_OE         2
`define PSH_FL_UE         3
`define PSH_FL_PE         4

`define PSH_ST_DONE       0
`define PSH_ST_UD         1
`define PSH_ST_SIMD       2
`define PSH_ST_W          3

`define PSH_RC_NEAR       2'h0
`define PSH_RC_DOWN       2'h1
`define PSH_RC_UP         2'h2
`define PSH_RC_TRUNC      2'h3

`define PSH_SP_BIAS       10'sh07F
`define PSH_HP_EMIN       10'sh3F2
`define PSH_HP_EMAX       10'sh00F
`define PSH_HP_REBIAS     10'sh00E
`define PSH_HP_FRSH       10'sh00D
`define PSH_SH_MAX        10'sh01F
`define PSH_HP_INF        15'h7C00
`define PSH_HP_MAXF       15'h7BFF
`define PSH_SP_EXP_ONES   8'hFF
`define PSH_HP_EXP_ONES   5'h1F

`endif

// file: src/psh_elem_cvt.v
// One single to half precision element converter
`timescale 1ns/1ns
`default_nettype none
`include "psh_defines.vh"
module psh_elem_cvt (
   input  wire [31:0] single,
   input  wire [1:0]  roundMode,
   input  wire        dazOn,
   output reg  [15:0] half,
   output reg         invalid,
   output reg         denormal,
   output reg         overflow,
   output reg         underflow,
   output reg         precision
);
   wire              sgn     = single[31];
   wire [7:0]        ex      = single[30:23];
   wire [22:0]       man     = single[22:0];
   wire              isSpec  = (ex == `PSH_SP_EXP_ONES);
   wire              isDen   = (ex == 8'h00) && (man != 23'h000000);
   wire              isZero  = (ex == 8'h00) && ((man == 23'h000000) || dazOn);
   wire signed [9:0] unb     = $signed({2'h0, (ex == 8'h00) ? 8'h01 : ex}) - `PSH_SP_BIAS;
   wire              tiny    = (unb < `PSH_HP_EMIN);
   wire              big     = (unb > `PSH_HP_EMAX);
   wire signed [9:0] shS     = tiny ? (-10'sh001 - unb) : `PSH_HP_FRSH;
   wire [4:0]        shift   = (shS > `PSH_SH_MAX) ? 5'h1F : shS[4:0];
   wire [55:0]       wide    = {ex != 8'h00, man, 32'h00000000} >> shift;
   wire [10:0]       kept    = wide[42:32];
   wire              guard   = wide[31];
   wire              sticky  = |wide[30:0];
   wire              inexact = guard | sticky;
   wire signed [9:0] ebS     = unb + `PSH_HP_REBIAS;
   wire [4:0]        eb      = tiny ? 5'h00 : ebS[4:0];
   reg               inc;
   wire [11:0]       rnd     = {1'b0, kept} + {11'h000, inc};
   wire [15:0]       sum     = {1'b0, eb, 10'h000} + {4'h0, rnd};
   wire              ovf     = big | (sum[14:0] >= `PSH_HP_INF);
   always @* begin
      case (roundMode)
         `PSH_RC_NEAR: inc = guard & (sticky | kept[0]);
         `PSH_RC_DOWN: inc = sgn & inexact;
         `PSH_RC_UP:   inc = ~sgn & inexact;
         default:      inc = 1'b0;
      endcase
   end
   always @* begin
      half      = {sgn, 15'h0000};
      invalid   = 1'b0;
      denormal  = 1'b0;
      overflow  = 1'b0;
      underflow = 1'b0;
      precision = 1'b0;
      if (isSpec) begin
         if (man != 23'h000000) begin
            half    = {sgn, `PSH_HP_EXP_ONES, 1'b1, man[21:13]};
            invalid = ~man[22];
         end else begin
            half = {sgn, `PSH_HP_INF};
         end
      end else if (!isZero) begin
         denormal = isDen;
         if (ovf) begin
            overflow  = 1'b1;
            precision = 1'b1;
            case (roundMode)
               `PSH_RC_NEAR: half = {sgn, `PSH_HP_INF};
               `PSH_RC_DOWN: half = {sgn, sgn ? `PSH_HP_INF : `PSH_HP_MAXF};
               `PSH_RC_UP:   half = {sgn, sgn ? `PSH_HP_MAXF : `PSH_HP_INF};
               default:      half = {sgn, `PSH_HP_MAXF};
            endcase
         end else begin
            half      = {sgn, sum[14:0]};
            precision = inexact;
            underflow = tiny & inexact;
         end
      end
   end
endmodule // psh_elem_cvt
`default_nettype wire

// file: src/psh_converter.v
// Packed single to half converter with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
`include "psh_defines.vh"
module psh_converter #(
   parameter LANES = 8
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [6:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   input  wire [3:0]  byteenable,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   output wire        irq,
   output reg         udFault_ff,
   output reg         simdFault_ff
);
   // Bus handshake: one wait state per access
   reg         ack_ff;
   wire        nxt_ack   = (read | write) & ~ack_ff;
   wire        wrTake    = write & ack_ff;
   wire [31:0] beMask    = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
   wire [4:0]  idx       = address[6:2];
   assign waitrequest = (read | write) & ~ack_ff;

   reg  [27:0] insn_ff;
   reg  [16:0] csr_ff;
   reg  [2:0]  stat_ff;
   reg  [2:0]  mask_ff;
   reg  [31:0] src_ff [0:LANES-1];
   reg  [31:0] dst_ff [0:LANES-1];
   reg  [31:0] mem_ff [0:LANES/2-1];
   reg         exec_ff;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [31:0] m;
      begin
         merge = (old & ~m) | (wd & m);
      end
   endfunction

   // Decode checks
   wire wideForm = insn_ff[`PSH_INSN_L];
   wire destReg  = (insn_ff[`PSH_INSN_MOD] == `PSH_MOD_REG);
   wire badEnc   = (insn_ff[`PSH_INSN_MAP] != `PSH_MAP_0F3A) |
                   (insn_ff[`PSH_INSN_OPC] != `PSH_OPC_CVT) |
                   (insn_ff[`PSH_INSN_PP] != `PSH_PP_66) |
                   insn_ff[`PSH_INSN_W] |
                   (insn_ff[`PSH_INSN_VVVV] != `PSH_VVVV_ONES);

   // Rounding source
   wire [1:0] roundSel = insn_ff[`PSH_INSN_MS] ? csr_ff[`PSH_CSR_RC] : insn_ff[`PSH_INSN_RC];
   wire       dazOn    = csr_ff[`PSH_CSR_DAZ];

   // Lane converters
   wire [15:0]      half  [0:LANES-1];
   wire [LANES-1:0] lnInv;
   wire [LANES-1:0] lnDen;
   wire [LANES-1:0] lnOvf;
   wire [LANES-1:0] lnUnf;
   wire [LANES-1:0] lnPre;
   wire [LANES-1:0] laneOn;
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : gLane
         assign laneOn[g] = wideForm | (g < LANES / 2);
         psh_elem_cvt uCvt (
            .single    (src_ff[g]),
            .roundMode (roundSel),
            .dazOn     (dazOn),
            .half      (half[g]),
            .invalid   (lnInv[g]),
            .denormal  (lnDen[g]),
            .overflow  (lnOvf[g]),
            .underflow (lnUnf[g]),
            .precision (lnPre[g])
         );
      end
   endgenerate

   // Exception gathering
   wire [4:0] masks  = csr_ff[`PSH_CSR_MASKS];
   wire       anyDen = |(lnDen & laneOn);
   wire       forceDen = anyDen & masks[`PSH_FL_DE] & (~masks[`PSH_FL_PE] | ~masks[`PSH_FL_UE]);
   reg  [4:0] raised;
   always @* begin
      raised = 5'h00;
      raised[`PSH_FL_IE] = |(lnInv & laneOn);
      raised[`PSH_FL_DE] = anyDen;
      raised[`PSH_FL_OE] = |(lnOvf & laneOn);
      raised[`PSH_FL_UE] = (|(lnUnf & laneOn)) | forceDen;
      raised[`PSH_FL_PE] = (|(lnPre & laneOn)) | forceDen;
   end
   wire unmaskedHit = |(raised & ~masks);
   wire simdFault   = unmaskedHit | forceDen;

   // Destination images
   wire [31:0] packWord [0:LANES-1];
   generate
      for (g = 0; g < LANES; g = g + 1) begin : gPack
         if (g < LANES / 2) begin : gLow
            assign packWord[g] = (laneOn[2*g+1]) ? {half[2*g+1], half[2*g]} : 32'h00000000;
         end else begin : gHigh
            assign packWord[g] = 32'h00000000;
         end
      end
   endgenerate

   // Events of the finished operation
   wire opDone = exec_ff & ~badEnc & ~simdFault;
   wire opUd   = exec_ff & badEnc;
   wire opSimd = exec_ff & ~badEnc & simdFault;
   reg  [2:0] evt;
   always @* begin
      evt = 3'h0;
      evt[`PSH_ST_DONE] = opDone;
      evt[`PSH_ST_UD]   = opUd;
      evt[`PSH_ST_SIMD] = opSimd;
   end

   wire [2:0]  stClr    = (wrTake && address == `PSH_OFF_STAT) ? (writedata[2:0] & beMask[2:0]) : 3'h0;
   wire [2:0]  nxt_stat = (stat_ff & ~stClr) | evt;
   wire [4:0]  flClr    = (wrTake && address == `PSH_OFF_CSR) ? (writedata[`PSH_CSR_FLAGS] & beMask[4:0]) : 5'h00;
   wire [4:0]  flSet    = (exec_ff & ~badEnc) ? raised : 5'h00;
   wire [4:0]  nxt_flags = (csr_ff[`PSH_CSR_FLAGS] & ~flClr) | flSet;
   wire [31:0] csrMerged = merge({15'h0000, csr_ff}, writedata, beMask);
   wire [31:0] insnMerged = merge({4'h0, insn_ff}, writedata, beMask);
   wire [31:0] maskMerged = merge({29'h00000000, mask_ff}, writedata, beMask);
   wire        startHit = wrTake && (address == `PSH_OFF_CTRL) && writedata[`PSH_CTRL_START] && byteenable[0];

   assign irq = |(stat_ff & mask_ff);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff       <= 1'b0;
         exec_ff      <= 1'b0;
         insn_ff      <= `PSH_INSN_RST;
         csr_ff       <= `PSH_CSR_RST;
         stat_ff      <= 3'h0;
         mask_ff      <= 3'h0;
         udFault_ff   <= 1'b0;
         simdFault_ff <= 1'b0;
      end else begin
         ack_ff       <= nxt_ack;
         exec_ff      <= startHit & ~exec_ff;
         stat_ff      <= nxt_stat;
         udFault_ff   <= opUd;
         simdFault_ff <= opSimd;
         if (wrTake && address == `PSH_OFF_INSN && !exec_ff)
            insn_ff <= insnMerged[27:0];
         if (wrTake && address == `PSH_OFF_MASK)
            mask_ff <= maskMerged[2:0];
         if (wrTake && address == `PSH_OFF_CSR && !exec_ff)
            csr_ff <= {csrMerged[16:5], nxt_flags};
         else
            csr_ff <= {csr_ff[16:5], nxt_flags};
      end
   end

   // Operand, register image and memory image words
   generate
      for (g = 0; g < LANES; g = g + 1) begin : gRegs
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               src_ff[g] <= 32'h00000000;
               dst_ff[g] <= 32'h00000000;
            end else begin
               if (wrTake && idx[4:3] == `PSH_IDX_SRC && idx[2:0] == g && !exec_ff)
                  src_ff[g] <= merge(src_ff[g], writedata, beMask);
               if (opDone && destReg)
                  dst_ff[g] <= packWord[g];
            end
         end
         if (g < LANES / 2) begin : gMem
            always @(posedge clk or negedge rst_n) begin
               if (!rst_n)
                  mem_ff[g] <= 32'h00000000;
               else if (opDone && !destReg && (wideForm || g < LANES / 4))
                  mem_ff[g] <= packWord[g];
            end
         end
      end
   endgenerate

   // Read data
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h00000000;
      end else if (read && !ack_ff) begin
         if (idx[4:3] == `PSH_IDX_SRC)
            readdata <= src_ff[idx[2:0]];
         else if (idx[4:3] == `PSH_IDX_DST)
            readdata <= dst_ff[idx[2:0]];
         else if (idx[4:2] == `PSH_IDX_MEM)
            readdata <= mem_ff[idx[1:0]];
         else begin
            case (address)
               `PSH_OFF_CTRL: readdata <= {31'h00000000, exec_ff};
               `PSH_OFF_INSN: readdata <= {4'h0, insn_ff};
               `PSH_OFF_CSR:  readdata <= {15'h0000, csr_ff};
               `PSH_OFF_STAT: readdata <= {29'h00000000, stat_ff};
               `PSH_OFF_MASK: readdata <= {29'h00000000, mask_ff};
               default:       readdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // psh_converter
`default_nettype wire

// file: test/psh_converter_properties.sv
// Port assertions for the packed single to half converter
`timescale 1ns/1ns
`default_nettype none
module psh_converter_properties #(
   parameter LANES = 8
) (
   input wire        clk,
   input wire        rst_n,
   input wire [6:0]  address,
   input wire        read,
   input wire        write,
   input wire [31:0] writedata,
   input wire [3:0]  byteenable,
   input wire [31:0] readdata,
   input wire        waitrequest,
   input wire        irq,
   input wire        udFault_ff,
   input wire        simdFault_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_wait;
      (read || write) && waitrequest;
   endsequence
   sequence s_go;
      write && !waitrequest && address == 7'h00 && writedata[0];
   endsequence
   chk_wait_first: assert property ((read || write) && !$past(read || write) |-> waitrequest)
      else $error("no first wait state");
   chk_wait_one: assert property (s_wait ##1 (read || write) |-> !waitrequest)
      else $error("extra wait state");
   chk_wait_idle: assert property (!(read || write) |-> !waitrequest)
      else $error("wait without request");
   chk_exec_quiet: assert property (s_go |=> !(udFault_ff || simdFault_ff))
      else $error("fault in exec cycle");
   chk_ud_cause: assert property (udFault_ff |-> $past(write && address == 7'h00, 2))
      else $error("undefined fault without start");
   chk_simd_cause: assert property (simdFault_ff |-> $past(write && address == 7'h00, 2))
      else $error("simd fault without start");
   chk_fault_excl: assert property (!(udFault_ff && simdFault_ff))
      else $error("both faults at once");
   chk_pulse_one: assert property (udFault_ff || simdFault_ff |=> !(udFault_ff || simdFault_ff))
      else $error("fault pulse too long");
   chk_rdata_hold: assert property (!read |=> $stable(readdata))
      else $error("read data moved");
   chk_irq_fall: assert property ($fell(irq) |-> $past(write))
      else $error("irq fell without write");
endmodule // psh_converter_properties
bind psh_converter psh_converter_properties #(.LANES(LANES)) u_props (.clk(clk), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .udFault_ff(udFault_ff),
   .simdFault_ff(simdFault_ff));
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the packed single to half converter
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [31:0] WREG = 32'h0FE71D00;
   localparam logic [31:0] NREG = 32'h0DE71D00;
   logic        clk, rstN, read, write, irq, udFault, simdFault, waitrequest;
   logic [6:0]  address;
   logic [31:0] writedata, readdata, rv;
   int          errorCnt = 0, numChecks = 0, cycles = 0;
   // Rows: round code, single input, expected half
   logic [49:0] rows [16] = '{
      {2'h0, 32'h3F800000, 16'h3C00}, {2'h0, 32'hC0000000, 16'hC000},
      {2'h0, 32'h477FE000, 16'h7BFF}, {2'h0, 32'h47C35000, 16'h7C00},
      {2'h1, 32'h47C35000, 16'h7BFF}, {2'h2, 32'h47C35000, 16'h7C00},
      {2'h3, 32'h47C35000, 16'h7BFF}, {2'h1, 32'hC7C35000, 16'hFC00},
      {2'h0, 32'h3F801000, 16'h3C00}, {2'h1, 32'h3F801000, 16'h3C00},
      {2'h2, 32'h3F801000, 16'h3C01}, {2'h3, 32'h3F801000, 16'h3C00},
      {2'h1, 32'hBF801000, 16'hBC01}, {2'h0, 32'h33000000, 16'h0000},
      {2'h2, 32'h33000000, 16'h0001}, {2'h0, 32'h7F800000, 16'h7C00}};
   logic [31:0] badInsn [3] = '{WREG | 32'h00100000, WREG & 32'hFE1FFFFF, WREG ^ 32'h00000100};
   psh_converter #(.LANES(8)) dut (.clk(clk), .rst_n(rstN), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .udFault_ff(udFault), .simdFault_ff(simdFault));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic completeRun();
      if (errorCnt == 0 && numChecks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errorCnt++;
         completeRun();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic busWr(input logic [6:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= 1'b1;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic busRd(input logic [6:0] a, output logic [31:0] d);
      address <= a;
      read <= 1'b1;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      d = readdata;
      read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic runOp(output logic [31:0] st);
      busWr(7'h00, 32'h1);
      st = 32'h0;
      for (int n = 0; n < 8 && st[2:0] == 3'h0; n++) busRd(7'h0C, st);
      busWr(7'h0C, 32'h7);
   endtask
   initial begin
      rstN = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 7'h00;
      writedata = 32'h0;
      repeat (8) @(posedge clk);
      rstN <= 1'b1;
      @(posedge clk);
      busRd(7'h08, rv); chk(rv, 32'h00001F00);
      for (int i = 0; i < 16; i++) begin
         busWr(7'(32 + 4 * (i % 8)), rows[i][47:16]);
         busWr(7'h04, WREG | {30'h0, rows[i][49:48]});
         runOp(rv); chk(rv, 32'h1);
         busRd(7'(64 + 4 * ((i % 8) / 2)), rv);
         chk({16'h0, rv[16 * (i % 2) +: 16]}, {16'h0, rows[i][15:0]});
      end
      busWr(7'h04, NREG | 32'hFA);
      runOp(rv);
      busRd(7'h40, rv); chk({16'h0, rv[15:0]}, 32'h3C01);
      for (int j = 2; j < 8; j++) begin
         busRd(7'(64 + 4 * j), rv); chk(rv, 32'h0);
      end
      busWr(7'h08, 32'h00015F00);
      busWr(7'h24, 32'h33800000);
      busWr(7'h04, WREG | 32'h4);
      runOp(rv);
      busRd(7'h40, rv); chk(rv, 32'h00013C01);
      busRd(7'h5C, rv); chk(rv, 32'h0);
      for (int j = 0; j < 3; j++) begin
         busWr(7'h04, badInsn[j]);
         runOp(rv); chk(rv, 32'h2);
      end
      busWr(7'h08, 32'h00000F1F);
      busWr(7'h20, 32'h00000001);
      busWr(7'h28, 32'h3F800000);
      busWr(7'h2C, 32'h3F800000);
      busWr(7'h04, NREG);
      runOp(rv); chk(rv, 32'h4);
      busRd(7'h08, rv); chk({27'h0, rv[4:0]}, 32'h1A);
      busRd(7'h40, rv); chk(rv, 32'h00013C01);
      busWr(7'h08, 32'h00002F1F);
      runOp(rv); chk(rv, 32'h1);
      busRd(7'h08, rv); chk({27'h0, rv[4:0]}, 32'h0);
      busWr(7'h08, 32'h00003F1F);
      busWr(7'h04, 32'h03E71D00);
      runOp(rv); chk(rv, 32'h1);
      busRd(7'h6C, rv); chk(rv, 32'h7C000000);
      busRd(7'h48, rv); chk(rv, 32'h0);
      busWr(7'h04, 32'h01E71D00);
      runOp(rv); chk(rv, 32'h1);
      busRd(7'h68, rv); chk(rv, 32'h0000BC00);
      busRd(7'h60, rv); chk(rv, 32'h00010000);
      busWr(7'h10, 32'h1);
      busWr(7'h00, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      busWr(7'h10, 32'h0); chk({31'h0, irq}, 32'h0);
      busWr(7'h10, 32'h1); chk({31'h0, irq}, 32'h1);
      busWr(7'h0C, 32'h1); chk({31'h0, irq}, 32'h0);
      busWr(7'h70, 32'hFFFFFFFF);
      busRd(7'h70, rv); chk(rv, 32'h0);
      rstN <= 1'b0;
      repeat (2) @(posedge clk);
      rstN <= 1'b1;
      @(posedge clk);
      busRd(7'h08, rv); chk(rv, 32'h00001F00);
      busRd(7'h10, rv); chk(rv, 32'h0);
      completeRun();
   end
endmodule // tb_top
`default_nettype wire
